// ### hw/ac_sense_cfg.svh
// Constants for the AC line sense flag monitor: addresses, fields, widths and timings.
`ifndef AC_SENSE_CFG_SVH
`define AC_SENSE_CFG_SVH

`define AC_APB_AW           20
`define AC_APB_DW           32
`define AC_IDX_GAIN_TRIM    16'hFE77
`define AC_IDX_SETTING      16'hFE78
`define AC_IDX_STATUS       16'h0010
`define AC_RST_GAIN_TRIM    8'h00
`define AC_RST_SETTING      8'h00

`define AC_TRIM_SIGN_BIT    7
`define AC_TRIM_MAG_HI      6
`define AC_TRIM_MAG_LO      0
`define AC_SET_PG_INC_BIT   7
`define AC_SET_PG_DEB_BIT   6
`define AC_SET_THR_HI       5
`define AC_SET_THR_LO       2
`define AC_SET_DEB_HI       1
`define AC_SET_DEB_LO       0

`define AC_ADC_W            12
`define AC_THR_W            4
`define AC_MAG_W            7
`define AC_TRIM_SHIFT       9
`define AC_FULL_SCALE_MV    1600
`define AC_HYST_MV          75

`define AC_CLK_KHZ          50000
`define AC_DEB_2P6_US       2600
`define AC_DEB_10P4_US      10400
`define AC_DEB_100_US       100000
`define AC_CNT_W            23

`endif

// ### hw/ac_sense_flag_monitor.sv
// AC line sense monitor: gain trim, threshold with hysteresis, debounce and power-good folding.
//
// Our own choice: the APB slave port.
`include "ac_sense_cfg.svh"

module ac_sense_flag_monitor
#(
  // The clock is scaled to MHz first, so the 100 ms product stays inside 32 bits.
  parameter int unsigned DEB_2P6_CYC  = `AC_DEB_2P6_US * (`AC_CLK_KHZ / 1000),
  parameter int unsigned DEB_10P4_CYC = `AC_DEB_10P4_US * (`AC_CLK_KHZ / 1000),
  parameter int unsigned DEB_100_CYC  = `AC_DEB_100_US * (`AC_CLK_KHZ / 1000)
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`AC_APB_AW-1:0]     paddr,
  input  wire logic [`AC_APB_DW-1:0]     pwdata,
  output logic      [`AC_APB_DW-1:0]     prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire ac_sense_pkg::adc_sample_s sense_sample,
  input  wire ac_sense_pkg::power_good_s power_good_in,
  output logic                           ac_line_sense,
  output logic                           power_good_first_channel,
  output logic                           power_good_second_channel
);
  import ac_sense_pkg::*;

  localparam logic [`AC_ADC_W-1:0] HYST_CNT =
    `AC_ADC_W'((`AC_HYST_MV * (1 << `AC_ADC_W)) / `AC_FULL_SCALE_MV);
  localparam logic [`AC_ADC_W-1:0] ADC_MAX  = {`AC_ADC_W{1'b1}};

  gain_trim_s            trim;
  setting_s              setting;
  logic [`AC_ADC_W-1:0]  trim_val;
  logic                  trim_valid;
  logic                  raw_flag;
  logic                  pg_flag;
  logic                  thr_zero;
  logic [1:0]            deb_flag;
  logic [`AC_CNT_W-1:0]  lim [2];

  assign thr_zero = (setting.threshold == `AC_THR_W'(0));

  ////////////////////////////////////////////////////////////////////////////
  // APB slave. Zero wait states; read data is caught in the setup cycle.

  function automatic logic [1:0] decode(input logic [`AC_APB_AW-1:0] addr);
    if (addr == `AC_APB_AW'(`AC_IDX_GAIN_TRIM * 4))
      return 2'h1;
    else if (addr == `AC_APB_AW'(`AC_IDX_SETTING * 4))
      return 2'h2;
    else if (addr == `AC_APB_AW'(`AC_IDX_STATUS * 4))
      return 2'h3;
    else
      return 2'h0;
  endfunction

  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim    <= `AC_RST_GAIN_TRIM;
      setting <= `AC_RST_SETTING;
    end
    else if (psel && penable && pwrite)
    begin
      if (decode(paddr) == 2'h1)
        trim <= pwdata[7:0];
      if (decode(paddr) == 2'h2)
        setting <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `AC_APB_DW'(0);
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= (decode(paddr) == 2'h0) || (pwrite && decode(paddr) == 2'h3);
      case (decode(paddr))
        2'h1:    prdata <= `AC_APB_DW'(trim);
        2'h2:    prdata <= `AC_APB_DW'(setting);
        2'h3:    prdata <= {12'h000, trim_val, 5'h00, pg_flag, raw_flag, ac_line_sense};
        default: prdata <= `AC_APB_DW'(0);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain trim. The correction is mag / 512 of the reading, so full trim is about 25 %.

  logic [`AC_ADC_W+`AC_MAG_W-1:0] trim_prod;
  logic [`AC_ADC_W:0]             trim_delta;
  logic [`AC_ADC_W+1:0]           trim_sum;

  always_comb
  begin
    trim_prod  = (`AC_ADC_W+`AC_MAG_W)'(sense_sample.value) * (`AC_ADC_W+`AC_MAG_W)'(trim.mag);
    trim_delta = (`AC_ADC_W+1)'(trim_prod >> `AC_TRIM_SHIFT);
    if (trim.sign)
      trim_sum = {2'b00, sense_sample.value} - {1'b0, trim_delta};
    else
      trim_sum = {2'b00, sense_sample.value} + {1'b0, trim_delta};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_val   <= `AC_ADC_W'(0);
      trim_valid <= 1'b0;
    end
    else
    begin
      trim_valid <= sense_sample.valid;
      if (sense_sample.valid)
        trim_val <= trim_sum[`AC_ADC_W] ? ADC_MAX : trim_sum[`AC_ADC_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold comparison. The flag marks a low line: it sets below the
  // threshold and clears once the value is a hysteresis step above it, or at once when the threshold is zero.

  logic [`AC_ADC_W:0] release_lvl;
  assign release_lvl = {1'b0, setting.threshold, 8'h00} + {1'b0, HYST_CNT};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw_flag <= 1'b0;
    else if (thr_zero)
      raw_flag <= 1'b0;
    else if (trim_valid)
    begin
      if (trim_val[`AC_ADC_W-1 -: `AC_THR_W] < setting.threshold)
        raw_flag <= 1'b1;
      else if ({1'b0, trim_val} >= release_lvl)
        raw_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debouncers: lane 0 drives the sense flag, lane 1 the power-good contribution.

  function automatic logic [`AC_CNT_W-1:0] deb_limit(input logic [1:0] code);
    case (code)
      2'h1:    return `AC_CNT_W'(DEB_2P6_CYC);
      2'h2:    return `AC_CNT_W'(DEB_10P4_CYC);
      2'h3:    return `AC_CNT_W'(DEB_100_CYC);
      default: return `AC_CNT_W'(0);
    endcase
  endfunction

  assign lim[0] = deb_limit(setting.debounce);
  assign lim[1] = deb_limit({1'b0, setting.pg_debounce});

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_deb
      logic [`AC_CNT_W-1:0] cnt;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cnt         <= `AC_CNT_W'(0);
          deb_flag[g] <= 1'b0;
        end
        else if (thr_zero || raw_flag == deb_flag[g])
        begin
          cnt <= `AC_CNT_W'(0);
          if (thr_zero)
            deb_flag[g] <= 1'b0;
        end
        else if (cnt + `AC_CNT_W'(1) >= lim[g])
        begin
          cnt         <= `AC_CNT_W'(0);
          deb_flag[g] <= raw_flag;
        end
        else
          cnt <= cnt + `AC_CNT_W'(1);
      end
    end
  endgenerate

  assign ac_line_sense = deb_flag[0];
  assign pg_flag       = deb_flag[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_good_first_channel  <= 1'b0;
      power_good_second_channel <= 1'b0;
    end
    else
    begin
      power_good_first_channel  <= power_good_in.first && !(setting.pg_include && pg_flag);
      power_good_second_channel <= power_good_in.second && !(setting.pg_include && pg_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_sample_low;
    trim_valid && !thr_zero && trim_val[`AC_ADC_W-1 -: `AC_THR_W] < setting.threshold;
  endsequence

  a_trim_negative: assert property (@(posedge pclk) disable iff (!presetn)
    sense_sample.valid && trim.sign |=> trim_val <= $past(sense_sample.value))
    else $error("negative trim raised the reading");
  a_trim_magnitude: assert property (@(posedge pclk) disable iff (!presetn)
    sense_sample.valid && trim.mag == `AC_MAG_W'(0) |=> trim_val == $past(sense_sample.value))
    else $error("zero trim changed the reading");
  a_pg_excluded: assert property (@(posedge pclk) disable iff (!presetn)
    !setting.pg_include |=> power_good_first_channel == $past(power_good_in.first)
      && power_good_second_channel == $past(power_good_in.second))
    else $error("power good altered while sense flag excluded");
  a_pg_masked: assert property (@(posedge pclk) disable iff (!presetn)
    setting.pg_include && pg_flag |=> !power_good_first_channel && !power_good_second_channel)
    else $error("power good high while sense flag folded in");
  a_pg_no_debounce: assert property (@(posedge pclk) disable iff (!presetn)
    !setting.pg_debounce && !thr_zero && raw_flag != pg_flag |=> pg_flag == $past(raw_flag))
    else $error("power good contribution delayed without debounce");
  a_thr_compare: assert property (@(posedge pclk) disable iff (!presetn)
    s_sample_low |=> raw_flag)
    else $error("sample below threshold did not set flag");
  a_hyst_hold: assert property (@(posedge pclk) disable iff (!presetn)
    trim_valid && raw_flag && !thr_zero && {1'b0, trim_val} < release_lvl |=> raw_flag)
    else $error("flag released inside hysteresis band");
  a_thr_zero_clear: assert property (@(posedge pclk) disable iff (!presetn)
    thr_zero |=> !raw_flag && !ac_line_sense)
    else $error("flag set with zero threshold");
  a_deb_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    setting.debounce == 2'h0 && !thr_zero && raw_flag != ac_line_sense |=> ac_line_sense == $past(raw_flag))
    else $error("flag delayed with zero debounce");
  a_deb_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ac_line_sense) |-> $past(raw_flag) && $past(g_deb[0].cnt) + `AC_CNT_W'(1) >= $past(lim[0]))
    else $error("flag changed before debounce interval elapsed");

endmodule

// ### hw/ac_sense_pkg.sv
// Types shared by the AC line sense flag monitor.
`include "ac_sense_cfg.svh"

package ac_sense_pkg;

  typedef struct packed
  {
    logic                 valid;
    logic [`AC_ADC_W-1:0] value;
  } adc_sample_s;

  typedef struct packed
  {
    logic                 sign;
    logic [`AC_MAG_W-1:0] mag;
  } gain_trim_s;

  typedef struct packed
  {
    logic                 pg_include;
    logic                 pg_debounce;
    logic [`AC_THR_W-1:0] threshold;
    logic [1:0]           debounce;
  } setting_s;

  typedef struct packed
  {
    logic first;
    logic second;
  } power_good_s;

endpackage

// ### sim/ac_line_source.sv
// Behavioural model of the sense converter that hands one result at a time to the monitor.
module ac_line_source
(
  input  wire logic                 pclk,
  output ac_sense_pkg::adc_sample_s sample
);
  timeunit 1ns;
  timeprecision 1ns;
  import ac_sense_pkg::*;

  initial sample = '{valid: 1'b0, value: 12'h5A5};

  // The data lines scramble between results, so a stale value never passes for a fresh one.
  task automatic send(input logic [11:0] v);
    @(posedge pclk);
    sample <= '{valid: 1'b1, value: v};
    @(posedge pclk);
    sample <= '{valid: 1'b0, value: ~v};
  endtask
endmodule

// ### sim/tb_ac_sense_flag_monitor.sv
// Self-checking testbench for the AC line sense flag monitor.
`include "ac_sense_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t %h %h", $time, (a), (b)); end end

module tb_ac_sense_flag_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  import ac_sense_pkg::*;

  localparam logic [19:0] A_TRIM = 20'(`AC_IDX_GAIN_TRIM) << 2;
  localparam logic [19:0] A_SET  = 20'(`AC_IDX_SETTING) << 2;
  localparam logic [19:0] A_STAT = 20'(`AC_IDX_STATUS) << 2;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, flag, pg1, pg2;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] v;
  logic [7:0]  t;
  logic [11:0] hv[4] = '{12'h100, 12'h4BF, 12'h4C0, 12'h3FF};
  adc_sample_s sample;
  power_good_s pgin;
  logic [32:0] expq[$];
  int          n_fail, n_tests, n;

  ac_sense_flag_monitor #(.DEB_2P6_CYC(4), .DEB_10P4_CYC(8), .DEB_100_CYC(16)) ac_sense_flag_monitor_i
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_sample(sample),
   .power_good_in(pgin), .ac_line_sense(flag), .power_good_first_channel(pg1),
   .power_good_second_channel(pg2));

  ac_line_source ac_line_source_i (.pclk(pclk), .sample(sample));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : $urandom;
    if (!w)
      expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'($urandom), d}, 33'h0);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // Saturating gain correction in steps of one part in 512.
  function automatic logic [11:0] trimv(input logic [11:0] x, input logic [7:0] g);
    logic [19:0] c;
    logic [12:0] s;
    c = ({8'h0, x} * {13'h0, g[6:0]}) >> 9;
    s = g[7] ? {1'b0, x} - c[12:0] : {1'b0, x} + c[12:0];
    return s[12] ? 12'hFFF : s[11:0];
  endfunction

  // Read results are taken at the access edge, in the order they were requested.
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      `CHK({pslverr, prdata}, expq.pop_front())
    end
    else if (psel && penable && pready && pwrite)
    begin
      `CHK(pslverr, paddr != A_TRIM && paddr != A_SET)
    end

  initial
  begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    pgin = 2'b11;
    void'($urandom(62356));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, A_TRIM, 32'h0, 33'h0);
    xfer(1'b0, A_SET, 32'h0, 33'h0);
    xfer(1'b0, 20'h00100, 32'h0, {1'b1, 32'h0});
    wr(A_STAT, 8'hFF);
    wr(20'h00100, 8'h5A);
    t = 8'($urandom);
    wr(A_SET, t);
    xfer(1'b0, A_SET, 32'h0, {25'h0, t});
    wr(A_SET, 8'h00);
    repeat (6)
    begin
      v = 12'($urandom);
      t = 8'($urandom);
      pgin <= 2'($urandom);
      wr(A_TRIM, t);
      ac_line_source_i.send(v);
      tick(3);
      `CHK(flag, 1'b0)
      `CHK({pg1, pg2}, pgin)
      xfer(1'b0, A_STAT, 32'h0, {13'h0, trimv(v, t), 8'h00});
    end
    xfer(1'b0, A_TRIM, 32'h0, {25'h0, t});
    wr(A_TRIM, 8'h00);
    wr(A_SET, 8'h10);
    pgin <= 2'b11;
    for (int i = 0; i < 4; i++)
    begin
      ac_line_source_i.send(hv[i]);
      tick(3);
      `CHK(flag, i != 2)
    end
    `CHK({pg1, pg2}, 2'b11)
    xfer(1'b0, A_STAT, 32'h0, {13'h0, 12'h3FF, 8'h07});
    wr(A_SET, 8'h90);
    tick(2);
    `CHK({pg1, pg2}, 2'b00)
    ac_line_source_i.send(12'hFFF);
    tick(3);
    `CHK({pg1, pg2}, 2'b11)
    wr(A_SET, 8'hD0);
    ac_line_source_i.send(12'h100);
    tick(3);
    `CHK({pg1, pg2}, 2'b11)
    tick(8);
    `CHK({pg1, pg2}, 2'b00)
    for (int d = 1; d < 4; d++)
    begin
      n = 2 << d;
      wr(A_SET, 8'h10);
      ac_line_source_i.send(12'hFFF);
      tick(4);
      wr(A_SET, {6'b000100, d[1:0]});
      ac_line_source_i.send(12'h100);
      tick(n / 2);
      `CHK(flag, 1'b0)
      tick(n + 4);
      `CHK(flag, 1'b1)
    end
    ac_line_source_i.send(12'hFFF);
    tick(10);
    ac_line_source_i.send(12'h100);
    tick(12);
    `CHK(flag, 1'b1)
    ac_line_source_i.send(12'hFFF);
    tick(22);
    `CHK(flag, 1'b0)
    wrap_up;
  end
endmodule
